// ===== an_regs_pkg.sv
// Package: register map, field layout, reset values and carrier types for the autoneg registers
package an_regs_pkg;

    // ==========================================================
    // Register map (printed values are word indices; byte offsets are four times these)
    // ==========================================================
    localparam logic [2:0] IDX_ID_LOW = 3'h3;
    localparam logic [2:0] IDX_ADV = 3'h4;
    localparam logic [2:0] IDX_PARTNER = 3'h5;
    localparam logic [2:0] IDX_EXP = 3'h6;
    localparam logic [2:0] IDX_NXT_PAGE = 3'h7;
    localparam int ADDR_W = 5;
    localparam int ADDR_LSB = 2;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int ADV_NP = 15;
    localparam int ADV_RF = 13;
    localparam int ADV_PAUSE_LO = 10;
    localparam int ADV_T4 = 9;
    localparam int PA_ACK = 14;
    localparam int PA_RF = 13;
    localparam int PA_NP = 15;
    localparam int EXP_PDF = 4;
    localparam int EXP_LPNP = 3;
    localparam int EXP_NPA = 2;
    localparam int EXP_PR = 1;
    localparam int EXP_LPANA = 0;
    localparam int NP_NP = 15;
    localparam int NP_MP = 13;
    localparam int NP_ACK2 = 12;
    localparam int NP_TOG = 11;

    // ==========================================================
    // Reset values and write masks
    // ==========================================================
    // Identifier low word; value is arbitrary
    localparam logic [15:0] ID_LOW_VALUE = 16'h0A5C;
    // Adv reset without pause: tx/10 abilities set, selector 802.3
    localparam logic [15:0] ADV_RESET = 16'h01E1;
    // Writable bits: 15, 13, 11:10, 8:5, 4:0
    localparam logic [15:0] ADV_WMASK = 16'hADFF;
    localparam logic [15:0] NP_RESET = 16'h2001;
    // Writable bits: 15, 13, 12, 10:0
    localparam logic [15:0] NP_WMASK = 16'hB7FF;
    localparam logic [1:0] PAUSE_NONE = 2'h0;
    localparam logic [1:0] PAUSE_SYM = 2'h1;
    localparam logic [1:0] PAUSE_ASYM_PARTNER = 2'h2;
    localparam logic [1:0] PAUSE_BOTH = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Carrier types
    // ==========================================================
    // Events from the auto-negotiation engine
    typedef struct packed {
        logic page_valid;
        logic [15:0] page_word;
        logic partner_an_able;
        logic par_det_fault;
        logic tx_toggle_valid;
        logic tx_toggle;
    } an_event_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_RESP = 2'h1
    } rd_state_t;

    // Whole state of the register block
    typedef struct packed {
        logic [1:0] strap_sync;
        logic strap_done;
        logic [15:0] adv;
        logic [15:0] partner;
        logic [15:0] nxt_page;
        logic pdf_latch;
        logic pr_latch;
        logic partner_an_able;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        rd_state_t rd_state;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

endpackage : an_regs_pkg

// ===== phy_autoneg_register_set.sv
// Module: autoneg register set for one PHY port behind an AXI4-Lite slave
`timescale 1ns/1ps

// How it works
// - Identifier low word read only, writes ignored
// - Pause field encodes four flow-control options
// - Pause reset value comes from strap pin
// - TX and 10T abilities writable, reset one
// - T4 ability always reads zero
// - Remote fault writable, resets zero
// - Next page ability writable, resets zero
// - Partner page captured, acknowledge shown
// - Partner remote fault reflects received page
// - Parallel fault latches until read
// - Partner next page ability reported
// - Local next page able reads one
// - Page received latches until read
// - Partner autoneg able reported
// - Next page more-follows bit, resets zero
// - Message page bit, resets one
// - Second acknowledge bit, resets zero
// - Toggle read only, follows last word
module phy_autoneg_register_set (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Strap pin, asynchronous
    input wire logic pause_default_strap_pin,
    // Auto-negotiation engine events
    input wire an_regs_pkg::an_event_t an_event,
    // Advertised words toward the engine
    output logic [15:0] adv_word,
    output logic [15:0] tx_next_page_word,
    // AXI4-Lite write address
    input wire logic [an_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [an_regs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ==========================================================
    // State
    // ==========================================================
    an_regs_pkg::state_t state_r;
    an_regs_pkg::state_t state_nxt;
    logic [15:0] exp_word;
    logic [15:0] wr_word;
    logic [15:0] wr_mask;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic wr_fire;
    logic rd_fire;

    // Expansion status word assembled from latches and live state
    always_comb begin
        exp_word = 16'h0000;
        exp_word[an_regs_pkg::EXP_PDF] = state_r.pdf_latch;
        exp_word[an_regs_pkg::EXP_LPNP] = state_r.partner[an_regs_pkg::PA_NP];
        exp_word[an_regs_pkg::EXP_NPA] = 1'b1;
        exp_word[an_regs_pkg::EXP_PR] = state_r.pr_latch;
        exp_word[an_regs_pkg::EXP_LPANA] = state_r.partner_an_able;
    end

    // Handshake outputs
    assign s_axi_awready = !state_r.aw_held && !state_r.bvalid;
    assign s_axi_wready = !state_r.w_held && !state_r.bvalid;
    assign s_axi_arready = (state_r.rd_state == an_regs_pkg::RD_IDLE);
    assign s_axi_bvalid = state_r.bvalid;
    assign s_axi_bresp = state_r.bresp;
    assign s_axi_rvalid = (state_r.rd_state == an_regs_pkg::RD_RESP);
    assign s_axi_rdata = state_r.rdata;
    assign s_axi_rresp = state_r.rresp;
    assign adv_word = state_r.adv;
    assign tx_next_page_word = state_r.nxt_page;

    // Write decode: address and data may arrive in either order
    assign wr_fire = state_r.aw_held && state_r.w_held && !state_r.bvalid;
    assign wr_idx = state_r.aw_addr[an_regs_pkg::ADDR_W-1:an_regs_pkg::ADDR_LSB];
    assign rd_idx = s_axi_araddr[an_regs_pkg::ADDR_W-1:an_regs_pkg::ADDR_LSB];
    assign rd_fire = s_axi_arvalid && (state_r.rd_state == an_regs_pkg::RD_IDLE);
    assign wr_word = state_r.w_data[15:0];
    assign wr_mask = {{8{state_r.w_strb[1]}}, {8{state_r.w_strb[0]}}};

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        state_nxt = state_r;

        // Strap synchroniser, second stage only read
        state_nxt.strap_sync = {state_r.strap_sync[0], pause_default_strap_pin};
        if (!state_r.strap_done) begin
            state_nxt.strap_done = 1'b1;
            // Pause default taken from strap after release
            state_nxt.adv[an_regs_pkg::ADV_PAUSE_LO +: 2] = state_r.strap_sync[1]
                ? an_regs_pkg::PAUSE_BOTH : an_regs_pkg::PAUSE_NONE;
        end

        // Capture address and data holds
        if (s_axi_awready && s_axi_awvalid) begin
            state_nxt.aw_held = 1'b1;
            state_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wready && s_axi_wvalid) begin
            state_nxt.w_held = 1'b1;
            state_nxt.w_data = s_axi_wdata;
            state_nxt.w_strb = s_axi_wstrb;
        end

        // Register writes through per-register write masks
        if (wr_fire) begin
            state_nxt.aw_held = 1'b0;
            state_nxt.w_held = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp = an_regs_pkg::RESP_OKAY;
            unique case (wr_idx)
                an_regs_pkg::IDX_ADV: begin
                    // Pause, abilities, fault, next page writable; T4 kept zero
                    state_nxt.adv = (state_r.adv & ~(wr_mask & an_regs_pkg::ADV_WMASK))
                        | (wr_word & wr_mask & an_regs_pkg::ADV_WMASK);
                end
                an_regs_pkg::IDX_NXT_PAGE: begin
                    // Toggle bit excluded from mask
                    state_nxt.nxt_page = (state_r.nxt_page & ~(wr_mask & an_regs_pkg::NP_WMASK))
                        | (wr_word & wr_mask & an_regs_pkg::NP_WMASK);
                end
                an_regs_pkg::IDX_ID_LOW, an_regs_pkg::IDX_PARTNER, an_regs_pkg::IDX_EXP: begin
                    // Read-only words ignore writes
                    state_nxt.bresp = an_regs_pkg::RESP_OKAY;
                end
                default: begin
                    state_nxt.bresp = an_regs_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (state_r.bvalid && s_axi_bready) begin
            state_nxt.bvalid = 1'b0;
        end

        // Read channel
        unique case (state_r.rd_state)
            an_regs_pkg::RD_IDLE: begin
                if (rd_fire) begin
                    state_nxt.rd_state = an_regs_pkg::RD_RESP;
                    state_nxt.rresp = an_regs_pkg::RESP_OKAY;
                    state_nxt.rdata = 32'h0000_0000;
                    unique case (rd_idx)
                        an_regs_pkg::IDX_ID_LOW: begin
                            state_nxt.rdata = {16'h0000, an_regs_pkg::ID_LOW_VALUE};
                        end
                        an_regs_pkg::IDX_ADV: begin
                            state_nxt.rdata = {16'h0000, state_r.adv};
                        end
                        an_regs_pkg::IDX_PARTNER: begin
                            state_nxt.rdata = {16'h0000, state_r.partner};
                        end
                        an_regs_pkg::IDX_EXP: begin
                            state_nxt.rdata = {16'h0000, exp_word};
                            // Read clears latches; live events below re-set them
                            state_nxt.pdf_latch = 1'b0;
                            state_nxt.pr_latch = 1'b0;
                        end
                        an_regs_pkg::IDX_NXT_PAGE: begin
                            state_nxt.rdata = {16'h0000, state_r.nxt_page};
                        end
                        default: begin
                            state_nxt.rresp = an_regs_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            an_regs_pkg::RD_RESP: begin
                if (s_axi_rready) begin
                    state_nxt.rd_state = an_regs_pkg::RD_IDLE;
                end
            end
        endcase

        // Engine events; set wins over read clear
        if (an_event.page_valid) begin
            state_nxt.partner = an_event.page_word;
            state_nxt.partner[an_regs_pkg::PA_ACK] = 1'b1;
            state_nxt.pr_latch = 1'b1;
        end
        if (an_event.par_det_fault) begin
            state_nxt.pdf_latch = 1'b1;
        end
        state_nxt.partner_an_able = an_event.partner_an_able;
        if (an_event.tx_toggle_valid) begin
            state_nxt.nxt_page[an_regs_pkg::NP_TOG] = an_event.tx_toggle;
        end
        // Capability bit never advertised
        state_nxt.adv[an_regs_pkg::ADV_T4] = 1'b0;
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= '0;
            // Strap synchroniser keeps running so the level is valid at release
            state_r.strap_sync <= state_nxt.strap_sync;
            state_r.adv <= an_regs_pkg::ADV_RESET;
            state_r.nxt_page <= an_regs_pkg::NP_RESET;
            state_r.rd_state <= an_regs_pkg::RD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule : phy_autoneg_register_set

// ===== an_regs_chk.sv
// Checker: bus timing and register invariants of the autoneg registers
`timescale 1ns/1ps
module an_regs_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Engine side
    input wire an_regs_pkg::an_event_t an_event,
    input wire logic [15:0] adv_word,
    input wire logic [15:0] tx_next_page_word,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    // ==========================================
    // Properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write accepted while busy");
    rsv_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    t4_zero_a: assert property (!adv_word[9]) else $error("t4 bit set");
    adv_rst_a: assert property (!$past(aresetn) |-> adv_word[8:5] == 4'hF
        && !adv_word[15] && !adv_word[13]) else $error("advert reset wrong");
    np_rst_a: assert property (!$past(aresetn) |-> tx_next_page_word[15:11] == 5'h04)
        else $error("next page reset wrong");
    tog_load_a: assert property (an_event.tx_toggle_valid
        |=> tx_next_page_word[11] == $past(an_event.tx_toggle)) else $error("toggle lost");
endmodule : an_regs_chk

bind phy_autoneg_register_set an_regs_chk i_chk (.aclk(aclk), .aresetn(aresetn),
    .an_event(an_event), .adv_word(adv_word), .tx_next_page_word(tx_next_page_word),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

// ===== an_partner.sv
// Partner model: negotiation events from the far side
`timescale 1ns/1ps
module an_partner (
    // Clock
    input wire logic aclk,
    // Events toward the registers
    output an_regs_pkg::an_event_t an_event
);
    // Idle, no partner seen yet
    initial an_event = '0;
    // One base page, then the word goes stale
    task automatic page(input logic [15:0] w);
        @(posedge aclk);
        an_event.page_valid <= 1'b1;
        an_event.page_word <= w;
        an_event.partner_an_able <= 1'b1;
        @(posedge aclk);
        an_event.page_valid <= 1'b0;
        an_event.page_word <= ~w;
    endtask : page
    // One-cycle parallel detection fault
    task automatic fault();
        @(posedge aclk);
        an_event.par_det_fault <= 1'b1;
        @(posedge aclk);
        an_event.par_det_fault <= 1'b0;
    endtask : fault
    // Toggle of the word just sent
    task automatic tog(input logic t);
        @(posedge aclk);
        an_event.tx_toggle_valid <= 1'b1;
        an_event.tx_toggle <= t;
        @(posedge aclk);
        an_event.tx_toggle_valid <= 1'b0;
        an_event.tx_toggle <= ~t;
    endtask : tog
endmodule : an_partner

// ===== phy_autoneg_register_set_test.sv
// Testbench: register access, partner pages and latched status
`timescale 1ns/1ps
module phy_autoneg_register_set_test;
    // ==========================================
    // Signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic strap = 1'b1;
    wire an_regs_pkg::an_event_t an_event;
    logic [15:0] adv_word, np_word, v, w;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h3;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int mismatches = 0, n_checks = 0, cyc = 0;
    always #2 aclk = ~aclk;
    phy_autoneg_register_set i_dut (.aclk(aclk), .aresetn(aresetn),
        .pause_default_strap_pin(strap), .an_event(an_event), .adv_word(adv_word),
        .tx_next_page_word(np_word), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    an_partner i_pt (.aclk(aclk), .an_event(an_event));
    // ==========================================
    // Tasks
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    // Write one word, note the response
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr
    // Read one word, note the expected answer
    task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        rq.push_back({r, 16'h0000, e});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd
    // Compare answers in order, cut a hang short
    always @(posedge aclk) begin
        if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
        if (bvalid && bready) check({32'h0, bresp}, {32'h0, bq.pop_front()});
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            end_of_test();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h37DD8763));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(5'h0C, an_regs_pkg::ID_LOW_VALUE, 2'h0);
        rd(5'h10, 16'h0DE1, 2'h0);
        rd(5'h18, 16'h0004, 2'h0);
        rd(5'h1C, 16'h2001, 2'h0);
        rd(5'h04, 16'h0000, an_regs_pkg::RESP_SLVERR);
        wr(5'h08, 16'h1234, an_regs_pkg::RESP_SLVERR);
        wr(5'h0C, 16'hFFFF, 2'h0);
        rd(5'h0C, an_regs_pkg::ID_LOW_VALUE, 2'h0);
        $display("test 1 done");
        for (int p = 0; p < 4; p++) begin
            v = 16'($urandom()) | 16'h0200;
            v[11:10] = 2'(p);
            wr(5'h10, v, 2'h0);
            rd(5'h10, v & an_regs_pkg::ADV_WMASK, 2'h0);
            v = 16'($urandom());
            wr(5'h1C, v, 2'h0);
            rd(5'h1C, v & an_regs_pkg::NP_WMASK, 2'h0);
        end
        $display("test 2 done");
        w = 16'($urandom());
        i_pt.page(w);
        rd(5'h14, w | 16'h4000, 2'h0);
        rd(5'h18, {12'h000, w[15], 3'h7}, 2'h0);
        rd(5'h18, {12'h000, w[15], 3'h5}, 2'h0);
        i_pt.fault();
        rd(5'h18, {11'h000, 1'b1, w[15], 3'h5}, 2'h0);
        rd(5'h18, {12'h000, w[15], 3'h5}, 2'h0);
        i_pt.tog(1'b1);
        rd(5'h1C, (v & an_regs_pkg::NP_WMASK) | 16'h0800, 2'h0);
        $display("test 3 done");
        // Mid-run reset with the strap low: pause field must come up as none
        strap <= 1'b0;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(5'h10, 16'h01E1, 2'h0);
        rd(5'h1C, 16'h2001, 2'h0);
        $display("test 4 done");
        end_of_test();
    end
endmodule : phy_autoneg_register_set_test
